// ---- core/ptx_table_access.sv ----
// table read and table write executor with an apb register port
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ptx_map.svh"
module ptx_table_access import ptx_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output var ptx_mem_req_t mem_req,
	input wire logic [15:0] mem_rdata,
	input wire logic [2:0] irq_raw,
	output logic irq_vector,
	output logic [7:0] file_wdata,
	output logic [7:0] file_waddr,
	output logic file_we,
	output logic irq
);
	// instruction sequencer state
	ptx_state_t state_r;
	ptx_state_t state_nxt;
	// table pointer and table latch
	logic [15:0] table_pointer_r;
	logic [15:0] table_pointer_nxt;
	logic [15:0] table_latch_r;
	logic [15:0] table_latch_nxt;

	// instruction in flight
	logic [15:0] op_r;
	// interrupt status, mask and control
	logic [2:0] stat_r;
	logic [2:0] stat_nxt;
	logic [2:0] mask_r;
	logic [2:0] irq_en_r;
	logic global_irq_disable_r;
	// file byte source and data file write port
	logic [7:0] rdat_r;
	logic [7:0] rdat_nxt;
	logic [7:0] file_wdata_r;
	logic [7:0] file_waddr_r;
	logic file_we_r;

	// vectoring pulse, bus read data and memory request
	logic vec_r;
	logic [31:0] prdata_r;
	ptx_mem_req_t mem_req_r;
	ptx_mem_req_t mem_req_nxt;

	// apb phase decode
	wire setup = psel & ~penable;
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire rd_setup = setup & ~pwrite;

	// apb address decode
	wire hit_ctrl = paddr == `PTX_OFF_CTRL;
	wire hit_ptr = paddr == `PTX_OFF_PTR;
	wire hit_lat = paddr == `PTX_OFF_LAT;
	wire hit_op = paddr == `PTX_OFF_OP;
	wire hit_stat = paddr == `PTX_OFF_STAT;
	wire hit_mask = paddr == `PTX_OFF_MASK;
	wire hit_rdat = paddr == `PTX_OFF_RDAT;
	wire hit_busy = paddr == `PTX_OFF_BUSY;
	wire mapped = hit_ctrl | hit_ptr | hit_lat | hit_op | hit_stat | hit_mask
		| hit_rdat | hit_busy;

	// an instruction is in flight whenever the sequencer is not idle
	wire busy = state_r != ST_IDLE;

	// zero wait state slave; unmapped accesses report an error
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// write strobes; software writes to pointer, latch and byte source are dropped while busy
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_ptr = wr & hit_ptr & ~busy;
	wire wr_lat = wr & hit_lat & ~busy;
	wire wr_stat = wr & hit_stat;
	wire wr_mask = wr & hit_mask;
	wire wr_rdat = wr & hit_rdat & ~busy;

	// fields of the opcode being written
	wire [15:0] new_op = pwdata[15:0];
	wire new_hi_ok = new_op[15:12] == `PTX_OP_HI;
	wire new_rd = new_hi_ok & (new_op[11:10] == `PTX_RD_LO);
	wire new_wr = new_hi_ok & (new_op[11:10] == `PTX_WR_LO);
	wire new_t = new_op[9]; // byte select
	wire [7:0] new_f = new_op[7:0]; // file register address

	// start pulse: a table opcode written while idle, anything else ignored
	wire start = wr & hit_op & ~busy & (new_rd | new_wr);
	wire start_rd = start & new_rd;
	wire start_wr = start & new_wr;

	// fields of the instruction in flight
	wire op_i = op_r[8]; // post increment
	wire [7:0] op_f = op_r[7:0];
	wire op_to_pcl = op_f == `PTX_PCL_ADDR;

	// latch byte chosen by the byte select
	wire [7:0] latch_byte = new_t ? table_latch_r[15:8] : table_latch_r[7:0];

	// pointer values below the limit address the on-chip eprom
	wire ptr_internal = table_pointer_r < `PTX_INT_LIMIT;

	// only sources with their mask bit set may end programming
	wire [2:0] term_src = irq_raw & mask_r & irq_en_r;
	wire term = |term_src;

	// ends of a long internal write and of a short external write
	wire long_end = (state_r == ST_WR_INT) & term;
	wire short_end = (state_r == ST_WR_EXT) & ~ptr_internal;

	// post increment points for read and write
	wire step_rd = (state_r == ST_RD2) & op_i;
	wire step_wr = (state_r == ST_WR_EXT) & op_i;

	// flags cleared as a table write ends
	// a long write clears its terminating source although it is raised now;
	// a short write clears every flag that is not raised in that cycle
	wire [2:0] auto_clr = long_end ? term_src : (short_end ? ~irq_raw : 3'h0);
	wire [2:0] w1c = wr_stat ? pwdata[2:0] : 3'h0;

	// read data mux
	wire [31:0] rd_mux =
		hit_ctrl ? {26'h0, irq_en_r, global_irq_disable_r, 2'h0} :
		hit_ptr ? {16'h0, table_pointer_r} :
		hit_lat ? {16'h0, table_latch_r} :
		hit_op ? {16'h0, op_r} :
		hit_stat ? {29'h0, stat_r} :
		hit_mask ? {29'h0, mask_r} :
		hit_rdat ? {24'h0, rdat_r} :
		hit_busy ? {31'h0, busy} : 32'h0;

	// next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_wr) begin
					state_nxt = ST_WR_EXT;
				end else if (start_rd) begin
					state_nxt = ST_RD2;
				end
			end
			// extra cycle when the counter low byte is the target
			ST_RD2: begin
				state_nxt = op_to_pcl ? ST_RD3 : ST_DONE;
			end
			ST_RD3: begin
				state_nxt = ST_DONE;
			end
			// external write ends here, internal one goes on
			ST_WR_EXT: begin
				state_nxt = ptr_internal ? ST_WR_INT : ST_DONE;
			end
			// programming runs until an enabled interrupt
			ST_WR_INT: begin
				state_nxt = term ? ST_DONE : ST_WR_INT;
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// pointer: loaded by software, stepped after fetch or write
	always_comb begin
		table_pointer_nxt = table_pointer_r;
		if (wr_ptr) begin
			table_pointer_nxt = pwdata[15:0];
		end else if (step_rd || step_wr) begin
			table_pointer_nxt = table_pointer_r + 16'h0001;
		end
	end

	// latch: software load, file byte on write, program word on read
	always_comb begin
		table_latch_nxt = table_latch_r;
		if (wr_lat) begin
			table_latch_nxt = pwdata[15:0];
		end
		// file byte into the chosen latch byte
		if (start_wr && new_t) begin
			table_latch_nxt[15:8] = rdat_r;
		end
		if (start_wr && !new_t) begin
			table_latch_nxt[7:0] = rdat_r;
		end
		// whole program word into the latch
		if (state_r == ST_RD2) begin
			table_latch_nxt = mem_rdata;
		end
	end

	// byte source: software load or the byte just copied to the file
	always_comb begin
		rdat_nxt = rdat_r;
		if (wr_rdat) begin
			rdat_nxt = pwdata[7:0];
		end else if (start_rd) begin
			rdat_nxt = latch_byte;
		end
	end

	// sticky status: a new event wins over a software clear
	always_comb begin
		stat_nxt = ((stat_r & ~w1c) | irq_raw) & ~auto_clr;
	end

	// program memory request, strobes last one cycle unless programming
	always_comb begin
		mem_req_nxt = mem_req_r;
		mem_req_nxt.we = 1'b0;
		mem_req_nxt.re = 1'b0;
		if (start_rd) begin
			mem_req_nxt.addr = table_pointer_r;
			mem_req_nxt.re = 1'b1;
		end
		// pointer as address, latch as data, one strobe for an external pointer
		if (state_r == ST_WR_EXT) begin
			mem_req_nxt.addr = table_pointer_r;
			mem_req_nxt.data = table_latch_r;
			mem_req_nxt.we = ~ptr_internal;
		end
		// programming strobe held until the terminating interrupt
		if (state_r == ST_WR_INT) begin
			mem_req_nxt.data = table_latch_r;
			mem_req_nxt.we = ~term;
		end
	end

	// sequencer state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// table pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_pointer_r <= 16'h0000;
		end else begin
			table_pointer_r <= table_pointer_nxt;
		end
	end

	// table latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_latch_r <= 16'h0000;
		end else begin
			table_latch_r <= table_latch_nxt;
		end
	end

	// instruction register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r <= 16'h0000;
		end else if (start) begin
			op_r <= new_op;
		end
	end

	// interrupt status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= 3'h0;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= 3'h0;
		end else if (wr_mask) begin
			mask_r <= pwdata[2:0];
		end
	end

	// global disable and per-source programming enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_irq_disable_r <= 1'b0;
			irq_en_r <= 3'h0;
		end else if (wr_ctrl) begin
			global_irq_disable_r <= pwdata[2];
			irq_en_r <= pwdata[5:3];
		end
	end

	// file byte source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdat_r <= 8'h00;
		end else begin
			rdat_r <= rdat_nxt;
		end
	end

	// data file write port, one pulse per table read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			file_we_r <= 1'b0;
			file_waddr_r <= 8'h00;
			file_wdata_r <= 8'h00;
		end else begin
			file_we_r <= start_rd;
			if (start_rd) begin
				file_waddr_r <= new_f;
				file_wdata_r <= latch_byte;
			end
		end
	end

	// program memory request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req_r <= '0;
		end else begin
			mem_req_r <= mem_req_nxt;
		end
	end

	// vector only when global disable is clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_r <= 1'b0;
		end else begin
			vec_r <= long_end & ~global_irq_disable_r;
		end
	end

	// read data captured in the setup phase, stable at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (rd_setup) begin
			prdata_r <= rd_mux;
		end
	end

	// outputs
	assign prdata = prdata_r;
	assign mem_req = mem_req_r;
	assign file_wdata = file_wdata_r;
	assign file_waddr = file_waddr_r;
	assign file_we = file_we_r;
	assign irq_vector = vec_r;
	// level interrupt while any unmasked status bit is set
	assign irq = |(stat_r & mask_r);
endmodule
`default_nettype wire

// ---- core/ptx_map.svh ----
// constants for the program memory table access block
`ifndef PTX_MAP_SVH
`define PTX_MAP_SVH
`define PTX_OP_HI 4'hA
`define PTX_RD_LO 2'h2
`define PTX_WR_LO 2'h3
`define PTX_PCL_ADDR 8'h02
`define PTX_INT_LIMIT 16'h0800
`define PTX_IRQ_PIN 0
`define PTX_IRQ_TMR 1
`define PTX_IRQ_TX 2
`define PTX_OFF_CTRL 12'h000
`define PTX_OFF_PTR 12'h004
`define PTX_OFF_LAT 12'h008
`define PTX_OFF_OP 12'h00C
`define PTX_OFF_STAT 12'h010
`define PTX_OFF_MASK 12'h014
`define PTX_OFF_RDAT 12'h018
`define PTX_OFF_BUSY 12'h01C
`endif

// ---- core/ptx_pkg.sv ----
// types for the program memory table access block
package ptx_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RD2, ST_RD3, ST_WR_EXT, ST_WR_INT, ST_DONE
	} ptx_state_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
		logic we;
		logic re;
	} ptx_mem_req_t;
endpackage

// ---- test/ptx_table_access_assertions.sv ----
// checker for the table access block ports
`timescale 1ns/1ps
`default_nettype none
module ptx_table_access_assertions import ptx_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire ptx_mem_req_t mem_req,
	input wire logic [2:0] irq_raw,
	input wire logic irq_vector,
	input wire logic [7:0] file_waddr,
	input wire logic file_we
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// read opcode written to the opcode register
	wire rd_op = psel && penable && pwrite && paddr == 12'h00C && pwdata[15:10] == 6'h2A;
	a_read_fetch: assert property (rd_op |=> mem_req.re)
		else $error("no fetch");
	a_read_copy: assert property (rd_op |=> file_we && file_waddr == $past(pwdata[7:0]))
		else $error("no file write");
	a_read_nowrite: assert property (rd_op |=> !mem_req.we [*3])
		else $error("read wrote");
	a_fetch_once: assert property (mem_req.re |=> !mem_req.re)
		else $error("long fetch");
	a_ext_strobe: assert property (mem_req.we && mem_req.addr >= 16'h0800 |=> !mem_req.we)
		else $error("long strobe");
	a_prog_hold: assert property (mem_req.we && mem_req.addr < 16'h0800
		&& !(|{irq_raw, $past(irq_raw), $past(irq_raw, 2)}) |=> mem_req.we)
		else $error("early stop");
	a_vector_once: assert property (irq_vector |=> !irq_vector)
		else $error("long vector");
	a_vector_cause: assert property ($rose(irq_vector) |->
		$past(mem_req.we) || $past(mem_req.we, 2) || $past(mem_req.we, 3))
		else $error("stray vector");
	c_vector: cover property (irq_vector);
	c_fetch: cover property (mem_req.re);
	c_prog: cover property (mem_req.we && mem_req.addr < 16'h0800);
endmodule
bind ptx_table_access ptx_table_access_assertions u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.mem_req(mem_req), .irq_raw(irq_raw), .irq_vector(irq_vector),
	.file_waddr(file_waddr), .file_we(file_we));
`default_nettype wire

// ---- test/ptx_prog_mem.sv ----
// behavioural program memory
`timescale 1ns/1ps
`default_nettype none
module ptx_prog_mem import ptx_pkg::*; (
	input wire logic pclk,
	input wire ptx_mem_req_t mem_req,
	output logic [15:0] mem_rdata
);
	logic [15:0] dat_r;
	logic vld_r;
	logic [15:0] wr_r;
	// word of the address, held one cycle once released, then inverted every cycle
	assign mem_rdata = mem_req.re ? mem_req.addr ^ 16'h5A5A : (vld_r ? dat_r : ~dat_r);
	always_ff @(posedge pclk) begin
		vld_r <= mem_req.re;
		dat_r <= mem_rdata;
		if (mem_req.we) begin
			wr_r <= mem_req.data;
		end
	end
endmodule
`default_nettype wire

// ---- test/ptx_table_access_tb_top.sv ----
// bench for the table access block
`timescale 1ns/1ps
`default_nettype none
module ptx_table_access_tb_top import ptx_pkg::*;;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq_vector, file_we, irq, err;
	logic [7:0] file_wdata, file_waddr, fw;
	logic [15:0] mem_rdata, wa, wd;
	logic [2:0] irq_raw = 3'h0;
	ptx_mem_req_t mem_req;
	integer seed = 51482, miscompares = 0, cmp_count = 0, nv = 0, p, l, b;
	always #2 pclk = ~pclk;
	ptx_table_access DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata), .irq_raw(irq_raw),
		.irq_vector(irq_vector), .file_wdata(file_wdata), .file_waddr(file_waddr),
		.file_we(file_we), .irq(irq));
	ptx_prog_mem u_mem (.pclk(pclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
	// capture of design results
	always @(posedge pclk) begin
		if (file_we === 1'h1) fw = file_wdata;
		if (mem_req.we === 1'h1) wa = mem_req.addr;
		if (mem_req.we === 1'h1) wd = mem_req.data;
		if (irq_vector === 1'h1) nv = nv + 1;
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task chk(input logic [31:0] e, input logic [31:0] g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("MISMATCH %0t exp %h got %h", $time, e, g);
		end
	endtask
	task idle;
		do apb(1'h0, 12'h01C, 32'h0); while (rd[0] !== 1'h0);
	endtask
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// hang guard
	initial begin
		#40000;
		miscompares = miscompares + 1;
		report_and_stop;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		p = 32'h0800 + ($random(seed) & 32'h77FF);
		l = $random(seed) & 32'hFFFF;
		b = $random(seed) & 32'hFF;
		apb(1'h1, 12'h004, p);
		apb(1'h1, 12'h008, l);
		// high byte to file with increment
		apb(1'h1, 12'h00C, 32'hAB50);
		idle;
		chk(l >> 8, fw);
		l = p ^ 32'h5A5A;
		p = p + 1;
		apb(1'h0, 12'h008, 32'h0);
		chk(l, rd);
		apb(1'h0, 12'h004, 32'h0);
		chk(p, rd);
		// low byte then external store with increment
		apb(1'h1, 12'h018, b);
		apb(1'h1, 12'h00C, 32'hAD50);
		idle;
		l = (l & 32'hFF00) | b;
		chk((p << 16) | l, {wa, wd});
		apb(1'h0, 12'h004, 32'h0);
		chk(p + 1, rd);
		// internal programming, masked pin then unmasked timer
		// pin source masked first
		apb(1'h1, 12'h014, 32'h2);
		apb(1'h1, 12'h000, 32'h38);
		apb(1'h1, 12'h004, 32'h10);
		apb(1'h1, 12'h00C, 32'hAC60);
		irq_raw <= 3'h1;
		repeat (4) @(posedge pclk);
		apb(1'h0, 12'h01C, 32'h0);
		chk(32'h1, rd[0]);
		chk(32'h0, irq);
		irq_raw <= 3'h2;
		@(posedge pclk);
		irq_raw <= 3'h0;
		idle;
		chk(32'h1, nv);
		apb(1'h0, 12'h010, 32'h0);
		chk(32'h1, rd);
		// global disable set: write ends, no vectoring
		apb(1'h1, 12'h000, 32'h3C);
		apb(1'h1, 12'h00C, 32'hAC60);
		repeat (2) @(posedge pclk);
		irq_raw <= 3'h2;
		@(posedge pclk);
		irq_raw <= 3'h0;
		idle;
		chk(32'h1, nv);
		apb(1'h0, 12'h020, 32'h0);
		chk(32'h1, err);
		report_and_stop;
	end
endmodule
`default_nettype wire
